//--- core/cic_evt_det.sv
`timescale 1ns/1ns
// Purpose: external pin edge detect and upper port pin mismatch detect
// Assumes: pins are synchronous to sys_clk
// Notes: latch is loaded during reset so no false mismatch follows release
module cic_evt_det (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ext_irq_pin,
	input wire logic [3:0] upper_port_pins,
	cic_evt_if.det evt
);
	import cic_pkg::*;

	logic pin_prev_q;
	logic [3:0] port_latch_q;

	always_ff @(posedge sys_clk) begin
		pin_prev_q <= ext_irq_pin;
	end

	// rising when select is 1, falling when 0
	always_comb begin
		if (rst) begin
			evt.ext_edge = 1'b0;
		end else if (evt.edge_sel) begin
			evt.ext_edge = ext_irq_pin & ~pin_prev_q;
		end else begin
			evt.ext_edge = ~ext_irq_pin & pin_prev_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || evt.relatch) begin
			port_latch_q <= upper_port_pins;
		end
	end

	// held high the whole time the mismatch lasts
	assign evt.mismatch = ~rst && (upper_port_pins != port_latch_q);
endmodule

//--- core/cic_top.sv
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
// Purpose: core interrupt control register with wishbone slave access
// Assumes: classic wishbone, 32-bit data, byte address = 4 * index
// Notes: control register mirrored at four indices; sticky event status
module cic_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [cic_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic timer0_overflow,
	input wire logic ext_irq_pin,
	input wire logic [3:0] upper_port_pins,
	input wire logic port_data_read,
	input wire logic periph_group_req,
	output logic core_irq_req,
	output logic irq
);
	import cic_pkg::*;

	function automatic logic idx_hit(input logic [ADR_W-1:0] adr, input logic [IDX_W-1:0] idx);
		idx_hit = (adr[ADR_W-1:2] == idx) && (adr[1:0] == 2'b00);
	endfunction

	function automatic logic is_ctrl(input logic [ADR_W-1:0] adr);
		is_ctrl = idx_hit(adr, IDX_IC_BANK0) || idx_hit(adr, IDX_IC_BANK1) ||
			idx_hit(adr, IDX_IC_BANK2) || idx_hit(adr, IDX_IC_BANK3);
	endfunction

	cic_evt_if evt ();

	logic [7:0] irq_control_reg_q;
	logic [7:0] irq_control_reg_d;
	logic [7:0] config_q;
	logic [EVT_W-1:0] evt_status_q;
	logic [EVT_W-1:0] evt_status_d;
	logic [EVT_W-1:0] evt_mask_q;
	logic [EVT_W-1:0] evt_raw;
	logic [31:0] rd_data_d;
	logic [31:0] wb_dat_q;
	logic wb_ack_q;
	logic core_irq_q;
	logic irq_q;
	logic bus_req;
	logic wr_en;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_sts;
	logic wr_msk;
	logic gate_src;
	cic_wb_state_t wb_state_q;

	cic_evt_det u_det (
		.sys_clk(sys_clk),
		.rst(rst),
		.ext_irq_pin(ext_irq_pin),
		.upper_port_pins(upper_port_pins),
		.evt(evt)
	);

	assign evt.edge_sel = config_q[BIT_EDGE_SEL];
	// port block signals the data register read; relatch ends the mismatch
	assign evt.relatch = port_data_read;

	// bus handshake: ack the cycle after a request, write at the acked edge
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign wr_en = bus_req && wb_we_i && wb_ack_q && wb_sel_i[0];
	assign wr_ctrl = wr_en && is_ctrl(wb_adr_i);
	assign wr_cfg = wr_en && idx_hit(wb_adr_i, IDX_CONFIG);
	assign wr_sts = wr_en && idx_hit(wb_adr_i, IDX_EVT_STATUS);
	assign wr_msk = wr_en && idx_hit(wb_adr_i, IDX_EVT_MASK);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wb_state_q <= WB_IDLE;
			wb_ack_q <= 1'b0;
		end else begin
			case (wb_state_q)
				WB_IDLE: begin
					if (bus_req) begin
						wb_state_q <= WB_ACK;
						wb_ack_q <= 1'b1;
					end
				end
				WB_ACK: begin
					wb_state_q <= WB_IDLE;
					wb_ack_q <= 1'b0;
				end
				default: begin
					wb_state_q <= WB_IDLE;
					wb_ack_q <= 1'b0;
				end
			endcase
		end
	end

	// unmapped reads return zero, unmapped writes are dropped
	always_comb begin
		rd_data_d = DATA_ZERO;
		if (is_ctrl(wb_adr_i)) begin
			rd_data_d[7:0] = irq_control_reg_q;
		end else if (idx_hit(wb_adr_i, IDX_CONFIG)) begin
			rd_data_d[7:0] = config_q;
		end else if (idx_hit(wb_adr_i, IDX_EVT_STATUS)) begin
			rd_data_d[EVT_W-1:0] = evt_status_q;
		end else if (idx_hit(wb_adr_i, IDX_EVT_MASK)) begin
			rd_data_d[EVT_W-1:0] = evt_mask_q;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wb_dat_q <= DATA_ZERO;
		end else if (bus_req && wb_state_q == WB_IDLE) begin
			wb_dat_q <= rd_data_d;
		end
	end

	// flag sets win over a software write in the same cycle
	always_comb begin
		irq_control_reg_d = irq_control_reg_q;
		if (wr_ctrl) begin
			irq_control_reg_d = wb_dat_i[7:0];
		end
		if (timer0_overflow) begin
			irq_control_reg_d[BIT_T0F] = 1'b1;
		end
		if (evt.ext_edge) begin
			irq_control_reg_d[BIT_EXF] = 1'b1;
		end
		// mismatch re-sets every cycle, so a clear only sticks after relatch or once the pins return to the latched value
		if (evt.mismatch) begin
			irq_control_reg_d[BIT_PCF] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_control_reg_q <= IC_RESET;
		end else begin
			irq_control_reg_q <= irq_control_reg_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			config_q <= CONFIG_RESET;
		end else if (wr_cfg) begin
			config_q <= wb_dat_i[7:0] & CONFIG_RESET;
		end
	end

	// masked sources, peripheral group behind its own enable
	always_comb begin
		gate_src = 1'b0;
		if (irq_control_reg_q[BIT_T0E] && irq_control_reg_q[BIT_T0F]) begin
			gate_src = 1'b1;
		end
		if (irq_control_reg_q[BIT_EXE] && irq_control_reg_q[BIT_EXF]) begin
			gate_src = 1'b1;
		end
		if (irq_control_reg_q[BIT_PCE] && irq_control_reg_q[BIT_PCF]) begin
			gate_src = 1'b1;
		end
		if (irq_control_reg_q[BIT_PGE] && periph_group_req) begin
			gate_src = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			core_irq_q <= 1'b0;
		end else begin
			core_irq_q <= irq_control_reg_q[BIT_GIE] && gate_src;
		end
	end

	// system-side sticky event log, write one to clear, set wins
	assign evt_raw[EVT_T0] = timer0_overflow;
	assign evt_raw[EVT_EX] = evt.ext_edge;
	assign evt_raw[EVT_PC] = evt.mismatch;

	always_comb begin
		evt_status_d = evt_status_q;
		if (wr_sts) begin
			evt_status_d = evt_status_q & ~wb_dat_i[EVT_W-1:0];
		end
		evt_status_d = evt_status_d | evt_raw;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			evt_status_q <= EVT_RESET;
		end else begin
			evt_status_q <= evt_status_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			evt_mask_q <= EVT_RESET;
		end else if (wr_msk) begin
			evt_mask_q <= wb_dat_i[EVT_W-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evt_status_q & evt_mask_q);
		end
	end

	assign wb_dat_o = wb_dat_q;
	assign wb_ack_o = wb_ack_q;
	assign core_irq_req = core_irq_q;
	assign irq = irq_q;
endmodule

//--- shared/cic_evt_if.sv
`timescale 1ns/1ns
// Purpose: carries source events from the detector to the register block
// Assumes: single clock domain
// Notes: all signals are one-cycle pulses or levels; ext_edge and mismatch are combinational from the pins
interface cic_evt_if;
	logic ext_edge;
	logic mismatch;
	logic edge_sel;
	logic relatch;
	modport det (output ext_edge, output mismatch, input edge_sel, input relatch);
	modport reg_side (input ext_edge, input mismatch, output edge_sel, output relatch);
endinterface

//--- shared/cic_pkg.sv
// Purpose: constants and types for the core interrupt control block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register indices; byte address on the bus is four times the index
// Summary of operation
// - the control register answers at indices 0Bh, 8Bh, 10Bh and 18Bh, all one physical register.
// - peripheral-group requests pass to the global gate only while the peripheral enable is 1.
// - timer0 overflow sets its flag, which requests only while its enable is 1 and stays until cleared.
// - the external pin enable masks the pending external flag.
// - the selected edge on the external pin sets its flag, which only software clears.
// - the port-change enable masks the port-change flag.
// - any upper port pin differing from its latched value sets the port-change flag.
// - while the mismatch lasts the flag is set again every cycle, so a clear does not stick.
// - a port data read relatches the upper pins and ends the mismatch; only software clears the flag.
// - each flag sets on its condition whatever the enables say.
// - the external flag follows a rising edge when edge select is 1 and a falling edge when 0.
package cic_pkg;
	localparam int ADR_W = 12;
	localparam int IDX_W = 10;
	// mirrored control register indices
	localparam logic [IDX_W-1:0] IDX_IC_BANK0 = 10'h00B;
	localparam logic [IDX_W-1:0] IDX_IC_BANK1 = 10'h08B;
	localparam logic [IDX_W-1:0] IDX_IC_BANK2 = 10'h10B;
	localparam logic [IDX_W-1:0] IDX_IC_BANK3 = 10'h18B;
	// block-level registers
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS = 10'h040;
	localparam logic [IDX_W-1:0] IDX_EVT_MASK = 10'h041;
	localparam logic [IDX_W-1:0] IDX_CONFIG = 10'h042;
	// control register fields
	localparam int BIT_GIE = 7;
	localparam int BIT_PGE = 6;
	localparam int BIT_T0E = 5;
	localparam int BIT_EXE = 4;
	localparam int BIT_PCE = 3;
	localparam int BIT_T0F = 2;
	localparam int BIT_EXF = 1;
	localparam int BIT_PCF = 0;
	// config register field
	localparam int BIT_EDGE_SEL = 6;
	// event status / mask layout
	localparam int EVT_T0 = 2;
	localparam int EVT_EX = 1;
	localparam int EVT_PC = 0;
	localparam int EVT_W = 3;
	localparam logic [7:0] IC_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h40;
	localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [1:0] {
		WB_IDLE,
		WB_ACK
	} cic_wb_state_t;
endpackage

//--- tb/cic_checker.sv
// Purpose: port checks for the interrupt control block
// Assumes: one clock, rst synchronous high
// Notes: enables and edge select are shadowed from bus writes
`timescale 1ns/1ns
module cic_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [cic_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic timer0_overflow,
	input wire logic ext_irq_pin,
	input wire logic [3:0] upper_port_pins,
	input wire logic port_data_read,
	input wire logic periph_group_req,
	input wire logic core_irq_req,
	input wire logic irq
);
	logic [4:0] en_q;
	logic sel_q;
	logic [3:0] latch_q;
	wire logic wack = wb_ack_o && wb_we_i && wb_sel_i[0];
	// flags are not shadowed: they are judged through core_irq_req
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			en_q <= 5'h00;
			sel_q <= 1'b1;
		end else if (wack && wb_adr_i[8:0] == 9'h02C && !wb_adr_i[11]) begin
			en_q <= wb_dat_i[7:3];
		end else if (wack && wb_adr_i == 12'h108) begin
			sel_q <= wb_dat_i[6];
		end
	end
	// a change back to the latched value is no mismatch
	always_ff @(posedge sys_clk) begin
		if (rst || port_data_read) begin
			latch_q <= upper_port_pins;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence req_up_s; $rose(wb_cyc_i && wb_stb_i); endsequence
	sequence req_two_s; ##2 core_irq_req; endsequence
	sequence ext_edge_s;
		en_q[4] && en_q[1] && (sel_q ? $rose(ext_irq_pin) : $fell(ext_irq_pin));
	endsequence
	ack_time_a: assert property (req_up_s |=> wb_ack_o)
		else $error("ack missing after request");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits set");
	gie_gate_a: assert property (core_irq_req |-> $past(en_q[4]))
		else $error("request without global enable");
	periph_pass_a: assert property (en_q[4] && en_q[3] && periph_group_req |=> core_irq_req)
		else $error("peripheral request blocked");
	t0_req_a: assert property (timer0_overflow && en_q[4] && en_q[2] |-> req_two_s)
		else $error("overflow request late");
	flag_hold_a: assert property (core_irq_req && !$past(wack) && !$past(en_q[3])
		|=> core_irq_req)
		else $error("flag request dropped without write");
	irq_hold_a: assert property (irq && !$past(wack) |=> irq)
		else $error("interrupt dropped without write");
	ext_edge_a: assert property (ext_edge_s |-> ##[1:4] core_irq_req)
		else $error("pin edge gave no request");
	pin_change_a: assert property ((upper_port_pins != latch_q) && en_q[4] && en_q[0]
		|-> ##[1:4] core_irq_req)
		else $error("port change gave no request");
endmodule
bind cic_top cic_checker cic_checker_i (.*);

//--- tb/cic_pins.sv
// Purpose: pins and port-read strobe around the interrupt block
// Assumes: called from the bench between clock edges
// Notes: v = {overflow, port read, ext pin, group req, upper pins}
`timescale 1ns/1ns
module cic_pins (
	input wire logic sys_clk,
	output logic timer0_overflow,
	output logic ext_irq_pin,
	output logic [3:0] upper_port_pins,
	output logic port_data_read,
	output logic periph_group_req
);
	initial begin
		{timer0_overflow, port_data_read, ext_irq_pin} = 3'h0;
		{periph_group_req, upper_port_pins} = 5'h00;
	end
	// the two strobes last one cycle, the rest stay as levels
	task automatic drive(input logic [7:0] v);
		@(posedge sys_clk);
		{timer0_overflow, port_data_read} <= v[7:6];
		{ext_irq_pin, periph_group_req, upper_port_pins} <= v[5:0];
		@(posedge sys_clk);
		{timer0_overflow, port_data_read} <= 2'h0;
	endtask
endmodule

//--- tb/cic_top_tb.sv
// Purpose: bus-driven test of the interrupt control block
// Assumes: request and interrupt levels settle within three edges
// Notes: control register mirrors sit at 0x02C plus multiples of 0x200
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %h got %h", nm, e, g); end end
module cic_top_tb;
	logic sys_clk, rst, cs, we, ack, req, irq, t0, ext, rdp, pgr;
	logic [11:0] adr;
	logic [31:0] dat, q, dat_o;
	logic [3:0] pins, sel;
	int n_errors = 0;
	int n_compared = 0;
	cic_pins cic_pins_i (.sys_clk(sys_clk), .timer0_overflow(t0), .ext_irq_pin(ext),
		.upper_port_pins(pins), .port_data_read(rdp), .periph_group_req(pgr));
	cic_top cic_top_i (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cs), .wb_stb_i(cs),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .timer0_overflow(t0), .ext_irq_pin(ext), .upper_port_pins(pins),
		.port_data_read(rdp), .periph_group_req(pgr), .core_irq_req(req), .irq(irq));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	function automatic logic [11:0] mir(input int i);
		return {1'b0, 2'(i), 9'h02C};
	endfunction
	task automatic print_verdict;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// s lets a scenario drop byte lane 0 and check that the write is ignored
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int n;
		n = 0;
		@(posedge sys_clk);
		cs <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		dat <= {24'h00_0000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = dat_o;
		cs <= 1'b0;
		if (n >= 16) begin
			n_errors++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hF);
		`CHK("read data", {24'h00_0000, e}, q)
	endtask
	task automatic lv(input logic er, input logic ei);
		repeat (3) @(posedge sys_clk);
		`CHK("core request", er, req)
		`CHK("interrupt line", ei, irq)
	endtask
	initial begin
		{rst, cs, we, adr, dat} = {3'h4, 12'h000, 32'h0000_0000};
		sel = 4'hF;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		rd(mir(0), 8'h00);
		rd(12'h108, 8'h40);
		rd(12'h0FC, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(mir(i), 8'h08 << i);
			rd(mir((i + 1) % 4), 8'h08 << i);
		end
		wr(mir(0), 8'h00);
		cic_pins_i.drive(8'h80);
		rd(mir(0), 8'h04);
		lv(1'b0, 1'b0);
		wr(mir(1), 8'h84);
		lv(1'b0, 1'b0);
		wr(mir(2), 8'hA0);
		lv(1'b0, 1'b0);
		cic_pins_i.drive(8'h80);
		lv(1'b1, 1'b0);
		wr(mir(0), 8'h90);
		cic_pins_i.drive(8'h20);
		lv(1'b1, 1'b0);
		rd(mir(3), 8'h92);
		wr(mir(0), 8'h82);
		lv(1'b0, 1'b0);
		wr(mir(0), 8'h90);
		cic_pins_i.drive(8'h00);
		lv(1'b0, 1'b0);
		wr(12'h108, 8'h00);
		cic_pins_i.drive(8'h20);
		lv(1'b0, 1'b0);
		cic_pins_i.drive(8'h00);
		rd(mir(0), 8'h92);
		wr(mir(0), 8'h88);
		cic_pins_i.drive(8'h0A);
		lv(1'b1, 1'b0);
		wr(mir(0), 8'h88);
		rd(mir(0), 8'h89);
		wr(mir(0), 8'h81);
		lv(1'b0, 1'b0);
		cic_pins_i.drive(8'h4A);
		wr(mir(0), 8'h88);
		rd(mir(0), 8'h88);
		wr(mir(0), 8'h80);
		cic_pins_i.drive(8'h1A);
		lv(1'b0, 1'b0);
		wr(mir(0), 8'hC0);
		lv(1'b1, 1'b0);
		bus(1'b1, mir(0), 8'h00, 4'hE);
		rd(mir(0), 8'hC0);
		rd(12'h100, 8'h07);
		wr(12'h104, 8'h04);
		lv(1'b1, 1'b1);
		wr(12'h100, 8'h04);
		rd(12'h100, 8'h03);
		lv(1'b1, 1'b0);
		wr(mir(0), 8'h40);
		lv(1'b0, 1'b0);
		print_verdict();
	end
endmodule
